// *** rtl/acs_calib_seq.sv ***
/*
  Calibration sequencer and result corrector of a sigma-delta converter:
  mode register, four calibration modes, settling timer, coefficients,
  ready flag and data-out/ready pin level.
  Assumes an external modulator and filter that deliver raw samples with
  a one-cycle valid, and a master clock that is clock_i.
*/
`timescale 1ns/1ps
module acs_calib_seq
  import acs_pkg::*;
#(
  parameter logic [2:0] OP_CONT     = 3'h0,
  parameter logic [2:0] OP_SINGLE   = 3'h1,
  parameter logic [2:0] OP_IDLE     = 3'h2,
  parameter logic [2:0] OP_PWRDN    = 3'h3,
  parameter logic [2:0] OP_INT_ZERO = 3'h4,
  parameter logic [2:0] OP_INT_FULL = 3'h5,
  parameter logic [2:0] OP_SYS_ZERO = 3'h6,
  parameter logic [2:0] OP_SYS_FULL = 3'h7,
  parameter int         CLKS_PER_FW = 1024,
  parameter int         PER_W       = 21
) (
  input  wire logic                             clock_i,
  input  wire logic                             rst_n_i,
  input  wire acs_pkg::acs_bus_req_s            bus_req_i,
  output logic          [acs_pkg::DATA_W-1:0]   rdata_o,
  input  wire logic                             cs_n_i,
  input  wire logic                             raw_valid_i,
  input  wire logic     [acs_pkg::SAMPLE_W-1:0] raw_data_i,
  output logic                                  dout_rdy_n_o,
  output logic                                  conv_restart_o,
  output logic                                  int_zero_sel_o,
  output logic                                  int_full_sel_o,
  output logic                                  clk_half_o,
  output logic          [acs_pkg::GAIN_W-1:0]   gain_o
);
  import acs_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SETTLE,
    ST_DIVIDE
  } acs_state_e;

  acs_state_e           state_q;
  acs_mode_s            mode_q;
  acs_cal_e             cal_q;
  logic [GAIN_W-1:0]    gain_q;
  logic [SAMPLE_W-1:0]  offset_q;
  logic [SAMPLE_W-1:0]  fscale_q;
  logic [SAMPLE_W-1:0]  data_q;
  logic [SAMPLE_W-1:0]  last_raw_q;
  logic                 ready_n_q;
  logic [PER_W-1:0]     clk_cnt_q;
  logic [4:0]           per_cnt_q;

  logic                 mode_wr;
  logic                 cal_start;
  acs_cal_e             cal_new;
  acs_mode_s            mode_new;
  logic [4:0]           settle_per;
  logic [4:0]           cal_per;
  logic [PER_W-1:0]     per_clks;
  logic                 settle_done;
  logic                 conv_store;
  logic                 div_done;
  logic [SAMPLE_W-1:0]  div_quot;
  logic                 div_start;
  logic [SAMPLE_W:0]    span;
  logic signed [SAMPLE_W:0]        diff;
  logic signed [2*SAMPLE_W+1:0]    product;
  logic signed [2*SAMPLE_W+1:0]    scaled;
  logic [SAMPLE_W-1:0]             corrected;

  // Fields taken one by one: the register leaves gaps the packed struct does not have
  assign mode_new = '{clk_div:     bus_req_i.wdata[MODE_CLKDIV_BIT],
                      sinc3:       bus_req_i.wdata[MODE_SINC3_BIT],
                      chop:        bus_req_i.wdata[MODE_CHOP_BIT],
                      filter_word: bus_req_i.wdata[MODE_FW_LSB +: FW_W],
                      op_mode:     bus_req_i.wdata[MODE_OP_LSB +: 3]};
  assign mode_wr  = bus_req_i.wr && bus_req_i.addr == MODE_OFS;

  // Code table kept as parameters so the map can be retargeted
  always_comb begin
    cal_new = CAL_INT_ZERO;
    unique case (mode_new.op_mode)
      OP_INT_FULL: cal_new = CAL_INT_FULL;
      OP_SYS_ZERO: cal_new = CAL_SYS_ZERO;
      OP_SYS_FULL: cal_new = CAL_SYS_FULL;
      default:     cal_new = CAL_INT_ZERO;
    endcase
  end

  // No gating on state or filter word: a new code always restarts
  assign cal_start = mode_wr && (mode_new.op_mode == OP_INT_ZERO ||
                                 mode_new.op_mode == OP_INT_FULL ||
                                 mode_new.op_mode == OP_SYS_ZERO ||
                                 mode_new.op_mode == OP_SYS_FULL);

  // Settling periods of the new calibration, taken from the written mode and, for internal full-scale, from the gain
  always_comb begin
    settle_per = mode_new.sinc3 ? SETTLE_SINC3 : SETTLE_SINC4;
    if (mode_new.chop) begin
      settle_per = SETTLE_CHOP;
    end
    cal_per = settle_per;
    if (cal_new == CAL_INT_FULL && gain_q != GAIN_RST) begin
      cal_per = {cal_per[3:0], 1'b0};
    end
    if (mode_new.clk_div) begin
      cal_per = {cal_per[3:0], 1'b0};
    end
  end

  // A zero filter word is treated as one to keep the timer finite
  assign per_clks = PER_W'(mode_q.filter_word == '0 ? 1 : mode_q.filter_word)
                  * PER_W'(CLKS_PER_FW);

  assign settle_done = state_q == ST_SETTLE && per_cnt_q == 5'h01 &&
                       clk_cnt_q == PER_W'(1);

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      state_q   <= ST_IDLE;
      cal_q     <= CAL_INT_ZERO;
      clk_cnt_q <= '0;
      per_cnt_q <= '0;
    end else if (cal_start) begin
      state_q   <= ST_SETTLE;
      cal_q     <= cal_new;
      clk_cnt_q <= PER_W'(mode_new.filter_word == '0 ? 1 : mode_new.filter_word)
                 * PER_W'(CLKS_PER_FW);
      per_cnt_q <= cal_per;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
        end
        ST_SETTLE: begin
          if (settle_done) begin
            state_q <= (cal_q == CAL_INT_FULL || cal_q == CAL_SYS_FULL) ?
                       ST_DIVIDE : ST_IDLE;
          end else if (clk_cnt_q == PER_W'(1)) begin
            clk_cnt_q <= per_clks;
            per_cnt_q <= per_cnt_q - 5'h01;
          end else begin
            clk_cnt_q <= clk_cnt_q - PER_W'(1);
          end
        end
        ST_DIVIDE: begin
          if (div_done) begin
            state_q <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // Internal inputs switched on only while their calibration settles
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      int_zero_sel_o <= 1'b0;
      int_full_sel_o <= 1'b0;
      conv_restart_o <= 1'b0;
    end else begin
      int_zero_sel_o <= cal_start ? cal_new == CAL_INT_ZERO :
                        int_zero_sel_o && !settle_done;
      int_full_sel_o <= cal_start ? cal_new == CAL_INT_FULL :
                        int_full_sel_o && !settle_done;
      conv_restart_o <= mode_wr;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      last_raw_q <= '0;
    end else if (raw_valid_i) begin
      last_raw_q <= raw_data_i;
    end
  end

  // Gain span measured against the present offset; negative spans saturate
  assign span      = {1'b0, last_raw_q} - {1'b0, offset_q};
  assign div_start = settle_done && (cal_q == CAL_INT_FULL || cal_q == CAL_SYS_FULL);

  acs_coef_divider #(
    .NUM_W (2*SAMPLE_W),
    .DEN_W (SAMPLE_W),
    .Q_W   (SAMPLE_W)
  ) u_div (
    .clock_i (clock_i),
    .rst_n_i (rst_n_i),
    .start_i (div_start),
    .num_i   ({FULL_CODE, {SAMPLE_W{1'b0}}} >> (SAMPLE_W - UNITY_SHIFT)),
    .den_i   (span[SAMPLE_W] ? '0 : span[SAMPLE_W-1:0]),
    .done_o  (div_done),
    .quot_o  (div_quot)
  );

  // Hardware updates follow the host write so a finishing calibration wins
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      offset_q <= OFFSET_RST;
      fscale_q <= FSCALE_RST;
    end else begin
      if (bus_req_i.wr && bus_req_i.addr == OFFS_OFS) begin
        offset_q <= bus_req_i.wdata[SAMPLE_W-1:0];
      end
      if (bus_req_i.wr && bus_req_i.addr == FSC_OFS) begin
        fscale_q <= bus_req_i.wdata[SAMPLE_W-1:0];
      end
      if (settle_done && (cal_q == CAL_INT_ZERO || cal_q == CAL_SYS_ZERO)) begin
        offset_q <= last_raw_q;
      end
      if (div_done && state_q == ST_DIVIDE && !cal_start) begin
        fscale_q <= div_quot;
      end
    end
  end

  // Offset first, then gain; result clamped to the unsigned code range
  assign diff      = $signed({1'b0, raw_data_i}) - $signed({1'b0, offset_q});
  assign product   = diff * $signed({1'b0, fscale_q});
  assign scaled    = product >>> UNITY_SHIFT;
  assign corrected = scaled < 0 ? '0 :
                     (|scaled[2*SAMPLE_W+1:SAMPLE_W]) ? {SAMPLE_W{1'b1}} :
                     scaled[SAMPLE_W-1:0];

  assign conv_store = raw_valid_i && state_q == ST_IDLE && !cal_start &&
                      (mode_q.op_mode == OP_CONT || mode_q.op_mode == OP_SINGLE);

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      data_q <= '0;
    end else if (conv_store) begin
      data_q <= corrected;
    end
  end

  // Mode returns to idle after a calibration or a single conversion
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      mode_q <= '{clk_div: 1'b0, sinc3: 1'b0, chop: 1'b0,
                  filter_word: FW_RST, op_mode: OP_RST};
      gain_q <= GAIN_RST;
    end else begin
      if ((settle_done && (cal_q == CAL_INT_ZERO || cal_q == CAL_SYS_ZERO)) ||
          (div_done && state_q == ST_DIVIDE) ||
          (conv_store && mode_q.op_mode == OP_SINGLE)) begin
        mode_q.op_mode <= OP_IDLE;
      end
      if (mode_wr) begin
        mode_q <= mode_new;
      end
      if (bus_req_i.wr && bus_req_i.addr == CONF_OFS) begin
        gain_q <= bus_req_i.wdata[CONF_GAIN_LSB +: GAIN_W];
      end
    end
  end

  // Start raises the flag; completion or new data lowers it ahead of a read
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      ready_n_q <= 1'b1;
    end else if (cal_start) begin
      ready_n_q <= 1'b1;
    end else if (conv_store ||
                 (settle_done && (cal_q == CAL_INT_ZERO || cal_q == CAL_SYS_ZERO)) ||
                 (div_done && state_q == ST_DIVIDE)) begin
      ready_n_q <= 1'b0;
    end else if (bus_req_i.rd && bus_req_i.addr == DATA_OFS) begin
      ready_n_q <= 1'b1;
    end
  end

  // Pin follows the flag only while selected; deselected it idles high
  assign dout_rdy_n_o = ready_n_q | cs_n_i;
  assign clk_half_o   = mode_q.clk_div;
  assign gain_o       = gain_q;

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      rdata_o <= '0;
    end else if (bus_req_i.rd) begin
      rdata_o <= '0;
      unique case (bus_req_i.addr)
        MODE_OFS: begin
          rdata_o[MODE_OP_LSB +: 3]    <= mode_q.op_mode;
          rdata_o[MODE_FW_LSB +: FW_W] <= mode_q.filter_word;
          rdata_o[MODE_CHOP_BIT]       <= mode_q.chop;
          rdata_o[MODE_SINC3_BIT]      <= mode_q.sinc3;
          rdata_o[MODE_CLKDIV_BIT]     <= mode_q.clk_div;
        end
        CONF_OFS: rdata_o[CONF_GAIN_LSB +: GAIN_W] <= gain_q;
        STAT_OFS: begin
          rdata_o[STAT_RDY_BIT]         <= ready_n_q;
          rdata_o[STAT_BUSY_BIT]        <= state_q != ST_IDLE;
          rdata_o[STAT_OP_LSB +: 3]     <= mode_q.op_mode;
        end
        DATA_OFS: rdata_o[SAMPLE_W-1:0] <= data_q;
        OFFS_OFS: rdata_o[SAMPLE_W-1:0] <= offset_q;
        FSC_OFS:  rdata_o[SAMPLE_W-1:0] <= fscale_q;
        default:  rdata_o <= '0;
      endcase
    end else begin
      rdata_o <= '0;
    end
  end

endmodule

// *** rtl/acs_pkg.sv ***
/*
  Shared constants and types for the calibration sequencer: register map,
  field positions, reset values, settling figures and the bus carrier.
  Assumes a single master clock domain and a simple strobe register port.
*/
package acs_pkg;

  localparam int ADDR_W   = 8;
  localparam int DATA_W   = 32;
  localparam int SAMPLE_W = 24;
  localparam int FW_W     = 10;
  localparam int GAIN_W   = 3;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] MODE_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] CONF_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] STAT_OFS = 8'h08;
  localparam logic [ADDR_W-1:0] DATA_OFS = 8'h0c;
  localparam logic [ADDR_W-1:0] OFFS_OFS = 8'h10;
  localparam logic [ADDR_W-1:0] FSC_OFS  = 8'h14;

  // Field positions
  localparam int MODE_OP_LSB     = 0;
  localparam int MODE_FW_LSB     = 4;
  localparam int MODE_CHOP_BIT   = 16;
  localparam int MODE_SINC3_BIT  = 17;
  localparam int MODE_CLKDIV_BIT = 18;
  localparam int CONF_GAIN_LSB   = 0;
  localparam int STAT_OP_LSB     = 0;
  localparam int STAT_BUSY_BIT   = 6;
  localparam int STAT_RDY_BIT    = 7;

  // Reset values
  localparam logic [2:0]          OP_RST     = 3'h0;
  localparam logic [FW_W-1:0]     FW_RST     = 10'h060;
  localparam logic [GAIN_W-1:0]   GAIN_RST   = 3'h0;
  localparam logic [SAMPLE_W-1:0] OFFSET_RST = 24'h000000;
  localparam logic [SAMPLE_W-1:0] FSCALE_RST = 24'h800000;

  // Full-scale coefficient of unity gain is 2**UNITY_SHIFT
  localparam int                  UNITY_SHIFT = 23;
  localparam logic [SAMPLE_W-1:0] FULL_CODE   = 24'hffffff;

  // Settling time in output-rate periods
  localparam logic [4:0] SETTLE_SINC4 = 5'h04;
  localparam logic [4:0] SETTLE_SINC3 = 5'h03;
  localparam logic [4:0] SETTLE_CHOP  = 5'h02;

  typedef enum logic [1:0] {
    CAL_INT_ZERO,
    CAL_INT_FULL,
    CAL_SYS_ZERO,
    CAL_SYS_FULL
  } acs_cal_e;

  typedef struct packed {
    logic            clk_div;
    logic            sinc3;
    logic            chop;
    logic [FW_W-1:0] filter_word;
    logic [2:0]      op_mode;
  } acs_mode_s;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } acs_bus_req_s;

endpackage

// *** rtl/acs_coef_divider.sv ***
/*
  Restoring divider that turns a full-scale measurement into a gain
  coefficient. One quotient bit per clock; a new start aborts a running one.
  Assumes the caller holds no expectation on quot_o until done_o pulses.
*/
`timescale 1ns/1ps
module acs_coef_divider #(
  parameter int NUM_W = 48,
  parameter int DEN_W = 24,
  parameter int Q_W   = 24
) (
  input  wire logic             clock_i,
  input  wire logic             rst_n_i,
  input  wire logic             start_i,
  input  wire logic [NUM_W-1:0] num_i,
  input  wire logic [DEN_W-1:0] den_i,
  output logic                  done_o,
  output logic      [Q_W-1:0]   quot_o
);
  localparam int CW = $clog2(NUM_W + 1);

  logic [NUM_W-1:0] quo_q;
  logic [DEN_W:0]   rem_q;
  logic [DEN_W-1:0] den_q;
  logic [CW-1:0]    cnt_q;
  logic             run_q;
  logic [DEN_W:0]   rem_shift;
  logic             fits;
  logic [NUM_W-1:0] quo_next;

  assign rem_shift = {rem_q[DEN_W-1:0], quo_q[NUM_W-1]};
  assign fits      = rem_shift >= {1'b0, den_q};
  assign quo_next  = {quo_q[NUM_W-2:0], fits};

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      quo_q <= '0;
      rem_q <= '0;
      den_q <= '0;
      cnt_q <= '0;
      run_q <= 1'b0;
    end else if (start_i) begin
      quo_q <= num_i;
      rem_q <= '0;
      den_q <= den_i;
      cnt_q <= CW'(NUM_W);
      run_q <= 1'b1;
    end else if (run_q) begin
      quo_q <= quo_next;
      rem_q <= fits ? rem_shift - {1'b0, den_q} : rem_shift;
      cnt_q <= cnt_q - 1'b1;
      run_q <= cnt_q != CW'(1);
    end
  end

  // Saturate: a zero or tiny span would otherwise wrap to a small gain
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      done_o <= 1'b0;
      quot_o <= '0;
    end else begin
      done_o <= run_q && !start_i && cnt_q == CW'(1);
      if (run_q && !start_i && cnt_q == CW'(1)) begin
        quot_o <= (|quo_next[NUM_W-1:Q_W]) ? {Q_W{1'b1}} : quo_next[Q_W-1:0];
      end
    end
  end

endmodule

// *** bench/acs_calib_seq_asserts.sv ***
/*
  Port checker for the calibration sequencer.
  Assumes the design top and a single clock; bound at the foot of this file.
*/
`timescale 1ns/1ps
module acs_calib_seq_chk
  import acs_pkg::*;
#(
  parameter logic [2:0] OP_INT_ZERO = 3'h4,
  parameter logic [2:0] OP_INT_FULL = 3'h5,
  parameter logic [2:0] OP_SYS_ZERO = 3'h6,
  parameter logic [2:0] OP_SYS_FULL = 3'h7,
  parameter int         CLKS_PER_FW = 1024
) (
  input  wire logic                             clock_i,
  input  wire logic                             rst_n_i,
  input  wire acs_pkg::acs_bus_req_s            bus_req_i,
  input  wire logic     [acs_pkg::DATA_W-1:0]   rdata_o,
  input  wire logic                             cs_n_i,
  input  wire logic                             raw_valid_i,
  input  wire logic     [acs_pkg::SAMPLE_W-1:0] raw_data_i,
  input  wire logic                             dout_rdy_n_o,
  input  wire logic                             conv_restart_o,
  input  wire logic                             int_zero_sel_o,
  input  wire logic                             int_full_sel_o,
  input  wire logic                             clk_half_o,
  input  wire logic     [acs_pkg::GAIN_W-1:0]   gain_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  logic       mode_wr;
  logic [2:0] wop;
  logic       cal_wr;
  assign mode_wr = bus_req_i.wr && (bus_req_i.addr == MODE_OFS);
  assign wop     = bus_req_i.wdata[2:0];
  assign cal_wr  = mode_wr && (wop == OP_INT_ZERO || wop == OP_INT_FULL ||
                               wop == OP_SYS_ZERO || wop == OP_SYS_FULL);

  chk_restart_mode: assert property (mode_wr |=> conv_restart_o)
    else $error("no restart pulse after a mode write");
  chk_cal_rdy_high: assert property (cal_wr |=> dout_rdy_n_o)
    else $error("ready pin not high after calibration start");
  chk_izs_select: assert property (mode_wr && wop == OP_INT_ZERO
    |=> int_zero_sel_o && !int_full_sel_o)
    else $error("internal zero input not connected");
  chk_ifs_select: assert property (mode_wr && wop == OP_INT_FULL
    |=> int_full_sel_o && !int_zero_sel_o)
    else $error("internal full-scale input not connected");
  chk_sys_no_select: assert property (mode_wr &&
    (wop == OP_SYS_ZERO || wop == OP_SYS_FULL) |=> !int_zero_sel_o && !int_full_sel_o)
    else $error("internal input connected during system calibration");
  chk_pin_cs_high: assert property (cs_n_i |-> dout_rdy_n_o)
    else $error("ready pin low while deselected");
  chk_zero_settle: assert property (mode_wr && wop == OP_SYS_ZERO
    && bus_req_i.wdata[MODE_CHOP_BIT] |=> dout_rdy_n_o [*2])
    else $error("chopped zero calibration ended early");
  chk_coef_width: assert property (bus_req_i.rd && (bus_req_i.addr == OFFS_OFS ||
    bus_req_i.addr == FSC_OFS) |=> rdata_o[31:24] == 8'h00)
    else $error("coefficient wider than 24 bits");
  chk_clk_half_mode: assert property (mode_wr
    |=> clk_half_o == $past(bus_req_i.wdata[MODE_CLKDIV_BIT]))
    else $error("clock halving does not follow mode write");
  chk_gain_follow: assert property (bus_req_i.wr && bus_req_i.addr == CONF_OFS
    |=> gain_o == $past(bus_req_i.wdata[CONF_GAIN_LSB +: GAIN_W]))
    else $error("gain output does not follow configuration write");
  chk_sel_busy: assert property (int_zero_sel_o || int_full_sel_o |-> dout_rdy_n_o)
    else $error("ready pin low while an internal input is connected");
endmodule

bind acs_calib_seq acs_calib_seq_chk #(
  .OP_INT_ZERO(OP_INT_ZERO), .OP_INT_FULL(OP_INT_FULL), .OP_SYS_ZERO(OP_SYS_ZERO),
  .OP_SYS_FULL(OP_SYS_FULL), .CLKS_PER_FW(CLKS_PER_FW)
) u_acs_calib_seq_chk (
  .clock_i(clock_i), .rst_n_i(rst_n_i), .bus_req_i(bus_req_i), .rdata_o(rdata_o),
  .cs_n_i(cs_n_i), .raw_valid_i(raw_valid_i), .raw_data_i(raw_data_i),
  .dout_rdy_n_o(dout_rdy_n_o), .conv_restart_o(conv_restart_o),
  .int_zero_sel_o(int_zero_sel_o), .int_full_sel_o(int_full_sel_o),
  .clk_half_o(clk_half_o), .gain_o(gain_o)
);

// *** bench/acs_host_model.sv ***
/*
  Host model on the register port: write, read and end-of-calibration wait.
  Assumes tasks are entered in the time step of a rising clock edge.
*/
`timescale 1ns/1ps
module acs_host_model
  import acs_pkg::*;
(
  input  wire logic                           clock_i,
  input  wire logic     [acs_pkg::DATA_W-1:0] rdata_i,
  input  wire logic                           dout_rdy_n_i,
  output acs_pkg::acs_bus_req_s               bus_req_o
);
  initial bus_req_o = '0;

  // Released lines carry inverted data so stale values are never trusted
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    bus_req_o <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock_i);
    bus_req_o <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
    @(posedge clock_i);
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    bus_req_o <= '{addr: a, wdata: '0, wr: 1'b0, rd: 1'b1};
    @(posedge clock_i);
    bus_req_o <= '{addr: ~a, wdata: '1, wr: 1'b0, rd: 1'b0};
    #1;
    d = rdata_i;
    @(posedge clock_i);
  endtask

  // Watches the pin rather than polling status, so no bus cycles are stolen
  task automatic wait_end(output int n);
    n = 1;
    #1;
    while (dout_rdy_n_i === 1'b1 && n < 5000) begin
      @(posedge clock_i);
      #1;
      n++;
    end
  endtask
endmodule

// *** bench/acs_calib_seq_bench.sv ***
/*
  Self-checking bench for the calibration sequencer with a short settling unit.
  Assumes the host model and the bound checker are compiled alongside.
*/
`timescale 1ns/1ps
module acs_calib_seq_bench;
  import acs_pkg::*;
  logic                clock_i     = 1'b0;
  logic                rst_n_i     = 1'b0;
  logic                cs_n_i      = 1'b0;
  logic                raw_valid_i = 1'b0;
  logic                src_en      = 1'b0;
  logic [SAMPLE_W-1:0] raw_val     = '0;
  acs_bus_req_s        bus_req;
  logic [DATA_W-1:0]   rdata;
  logic [DATA_W-1:0]   d;
  logic                dout_rdy_n;
  int                  err_total   = 0;
  int                  n_checks    = 0;
  int                  n;
  int                  nf [3];
  logic [7:0]          rst_a [6] = '{MODE_OFS, CONF_OFS, STAT_OFS, OFFS_OFS, FSC_OFS, 8'h20};
  logic [31:0]         rst_e [6] = '{32'h600, 32'h0, 32'h80, 32'h0, 32'h800000, 32'h0};
  logic [2:0]          z_op [6]  = '{3'h4, 3'h6, 3'h4, 3'h6, 3'h6, 3'h4};
  logic [9:0]          z_fw [6]  = '{10'h001, 10'h001, 10'h001, 10'h002, 10'h001, 10'h001};
  logic [2:0]          z_f [6]   = '{3'h1, 3'h1, 3'h2, 3'h2, 3'h0, 3'h6};
  int                  z_n [6]   = '{2, 2, 3, 6, 4, 6};
  logic [23:0]         c_raw [3] = '{24'h500000, 24'h050000, 24'hffffff};
  logic [31:0]         c_exp [3] = '{32'h200000, 32'h0, 32'h77ffff};

  always #12.5 clock_i = ~clock_i;
  // Sample source pulses every other cycle once enabled
  always @(posedge clock_i) raw_valid_i <= src_en & ~raw_valid_i;

  acs_calib_seq #(.CLKS_PER_FW(1)) u_acs_calib_seq (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .bus_req_i(bus_req), .rdata_o(rdata),
    .cs_n_i(cs_n_i), .raw_valid_i(raw_valid_i), .raw_data_i(raw_val),
    .dout_rdy_n_o(dout_rdy_n), .conv_restart_o(), .int_zero_sel_o(), .int_full_sel_o(),
    .clk_half_o(), .gain_o()
  );
  acs_host_model u_acs_host_model (
    .clock_i(clock_i), .rdata_i(rdata), .dout_rdy_n_i(dout_rdy_n), .bus_req_o(bus_req)
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic logic [31:0] mw(input logic [2:0] op, input logic [9:0] fw,
                                     input logic [2:0] f);
    return (32'(f) << MODE_CHOP_BIT) | (32'(fw) << MODE_FW_LSB) | 32'(op);
  endfunction

  task automatic cal(input logic [31:0] m, output int cnt);
    u_acs_host_model.wr(MODE_OFS, m);
    u_acs_host_model.wait_end(cnt);
    @(posedge clock_i);
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge clock_i);
    rst_n_i <= 1'b1;
    @(posedge clock_i);
    for (int i = 0; i < 6; i++) begin
      u_acs_host_model.rd(rst_a[i], d);
      chk(d, rst_e[i]);
    end
    // Samples held off until now, else the first store drops ready before status is read
    src_en <= 1'b1;
    $display("test reset_values done");
    for (int i = 0; i < 6; i++) begin
      raw_val <= 24'h010000 + 24'(i);
      cal(mw(z_op[i], z_fw[i], z_f[i]), n);
      chk(32'(n), 32'(z_n[i]));
      u_acs_host_model.rd(OFFS_OFS, d);
      chk(d, 32'h010000 + 32'(i));
      u_acs_host_model.rd(STAT_OFS, d);
      chk(d, 32'h2);
    end
    $display("test zero_scale done");
    u_acs_host_model.wr(OFFS_OFS, 32'h0);
    raw_val <= 24'hffffff;
    for (int i = 0; i < 3; i++) begin
      u_acs_host_model.wr(FSC_OFS, 32'h123456);
      u_acs_host_model.wr(CONF_OFS, 32'(i == 1));
      cal(mw((i == 2) ? 3'h7 : 3'h5, 10'h010, 3'h0), nf[i]);
      u_acs_host_model.rd(FSC_OFS, d);
      chk(d, 32'h800000);
    end
    chk(32'(nf[1] - nf[0]), 32'h40);
    chk(32'(nf[2]), 32'(nf[0]));
    chk(32'(nf[0] >= 64), 32'h1);
    $display("test full_scale done");
    u_acs_host_model.wr(OFFS_OFS, 32'h100000);
    u_acs_host_model.wr(FSC_OFS, 32'h400000);
    u_acs_host_model.wr(MODE_OFS, mw(3'h0, 10'h001, 3'h0));
    for (int i = 0; i < 3; i++) begin
      raw_val <= c_raw[i];
      repeat (6) @(posedge clock_i);
      u_acs_host_model.rd(DATA_OFS, d);
      chk(d, c_exp[i]);
    end
    u_acs_host_model.wr(MODE_OFS, mw(3'h1, 10'h001, 3'h0));
    repeat (4) @(posedge clock_i);
    u_acs_host_model.rd(STAT_OFS, d);
    chk(d, 32'h2);
    $display("test correction done");
    u_acs_host_model.wr(MODE_OFS, mw(3'h4, 10'h004, 3'h0));
    u_acs_host_model.rd(OFFS_OFS, d);
    chk(d, 32'h100000);
    cal(mw(3'h6, 10'h001, 3'h1), n);
    chk(32'(n), 32'h2);
    cs_n_i <= 1'b1;
    @(posedge clock_i);
    chk(32'(dout_rdy_n), 32'h1);
    cs_n_i <= 1'b0;
    @(posedge clock_i);
    chk(32'(dout_rdy_n), 32'h0);
    $display("test abort_and_select done");
    report_and_stop();
  end

  // Whole sequence needs well under two thousand cycles
  initial begin
    repeat (20000) @(posedge clock_i);
    err_total++;
    report_and_stop();
  end
endmodule
